//--- design/asbc_ctrl.sv
// Auxiliary sensor bus controller: slave to host, master to sensors
// What this block does
// - Device is only ever a target on the host bus, never initiates.
// - Host-bus target address low bit follows the address select strap.
// - Aux bus has two modes: autonomous master or host pass-through.
// - In master mode device fetches sensor registers for the coprocessor.
// - Burst read returns two bytes per axis for X, Y, Z.
// - Up to three burst slots, at most 24 bytes in total.
// - Fourth slot does only single-byte reads or writes.
// - In pass-through the aux master stays off and drives nothing.
// - In pass-through the aux lines are switched onto the host bus.
// - In pass-through the device still answers host transfers.
// - A missing sensor acknowledge raises an event.
`timescale 1ns/10ps
`include "asbc_params.svh"
module asbc_ctrl import asbc_pkg::*; #(
  parameter int unsigned FIFO_DEPTH  = `ASBC_FIFO_DEPTH,
  parameter logic [5:0]  PRI_ADDR_HI = `ASBC_PRI_ADDR_HI
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             pri_scl_in,
  input  wire logic             pri_sda_in,
  output logic                  pri_sda_out,
  output logic                  pri_sda_oe_n,
  input  wire logic             address_select_pin,
  input  wire logic             aux_bus_clock_in,
  output logic                  aux_bus_clock_out,
  output logic                  aux_bus_clock_oe_n,
  input  wire logic             aux_bus_data_in,
  output logic                  aux_bus_data_out,
  output logic                  aux_bus_data_oe_n,
  input  wire logic             bypass_en,
  input  wire logic             round_start,
  input  wire asbc_slot_t [3:0] slot_cfg,
  output asbc_word_t            stream_data,
  output logic                  stream_valid,
  input  wire logic             stream_ready,
  output logic      [7:0]       slot3_rdata,
  output logic                  aux_nack_event,
  output logic                  round_done,
  output logic                  busy,
  output logic                  bypass_switch_closed
);
  localparam logic [6:0] QTR_LAST  = 7'(`ASBC_QTR_CYC - 1);
  localparam logic [4:0] BURST_MAX = 5'(`ASBC_BURST_MAX);
  localparam logic [2:0] SLOT_END  = 3'(`ASBC_SLOT_COUNT);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Pin synchronisers: scl, sda, aux clock, aux data, strap
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [1:0] pri_prev;
  logic       pin_low;
  wire  [4:0] pin_raw = {address_select_pin, aux_bus_data_in,
                         aux_bus_clock_in, pri_sda_in, pri_scl_in};

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sync1    <= 5'h1F;
      sync2    <= 5'h1F;
      pri_prev <= 2'h3;
      pin_low  <= 1'b0;
    end
    else
    begin
      sync1    <= pin_raw;
      sync2    <= sync1;
      pri_prev <= sync2[1:0];
      pin_low  <= 1'b0;
    end
  end

  wire pri_scl_s  = sync2[0];
  wire pri_sda_s  = sync2[1];
  wire aux_scl_s  = sync2[2];
  wire aux_sda_s  = sync2[3];
  wire addr_lsb_s = sync2[4];

  // Open-drain pins only ever pull low
  assign pri_sda_out       = pin_low;
  assign aux_bus_clock_out = pin_low;
  assign aux_bus_data_out  = pin_low;

  // Host-side target
  asbc_slv_t  sl_state;
  logic [7:0] sl_sh;
  logic [2:0] sl_cnt;
  logic       sl_rw;
  wire  [6:0] own_addr = {PRI_ADDR_HI, addr_lsb_s};
  wire sl_rise  = pri_scl_s & ~pri_prev[0];
  wire sl_fall  = ~pri_scl_s & pri_prev[0];
  wire sl_start = pri_scl_s & pri_prev[0] & pri_prev[1] & ~pri_sda_s;
  wire sl_stop  = pri_scl_s & pri_prev[0] & ~pri_prev[1] & pri_sda_s;
  wire sl_match = (sl_sh[7:1] == own_addr);
  wire [7:0] sl_sh_in = {sl_sh[6:0], pri_sda_s};

  // Only ever answers; start and stop are seen even in pass-through
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sl_state     <= SL_IDLE;
      sl_sh        <= 8'h00;
      sl_cnt       <= 3'h0;
      sl_rw        <= 1'b0;
      pri_sda_oe_n <= 1'b1;
    end
    else if (sl_start)
    begin
      sl_state     <= SL_ADDR;
      sl_cnt       <= 3'h0;
      pri_sda_oe_n <= 1'b1;
    end
    else if (sl_stop)
    begin
      sl_state     <= SL_IDLE;
      pri_sda_oe_n <= 1'b1;
    end
    else
    begin
      unique case (sl_state)
        SL_IDLE: ;
        SL_ADDR, SL_WR:
          if (sl_rise)
          begin
            sl_sh  <= sl_sh_in;
            sl_cnt <= sl_cnt + 3'h1;
            if (sl_cnt == 3'h7)
              sl_state <= (sl_state == SL_ADDR) ? SL_ADEC : SL_WACK;
          end
        SL_ADEC:
          if (sl_fall)
          begin
            if (sl_match)
            begin
              pri_sda_oe_n <= 1'b0;
              sl_rw        <= sl_sh[0];
              sl_state     <= SL_ACK;
            end
            else
              sl_state <= SL_IDLE;
          end
        SL_WACK:
          if (sl_fall)
          begin
            pri_sda_oe_n <= 1'b0;
            sl_state     <= SL_ACK;
          end
        SL_ACK:
          if (sl_fall)
          begin
            sl_cnt <= 3'h0;
            if (sl_rw)
            begin
              pri_sda_oe_n <= slot3_rdata[7];
              sl_sh        <= {slot3_rdata[6:0], 1'b0};
              sl_state     <= SL_RD;
            end
            else
            begin
              pri_sda_oe_n <= 1'b1;
              sl_state     <= SL_WR;
            end
          end
        SL_RD:
          if (sl_fall)
          begin
            sl_cnt       <= sl_cnt + 3'h1;
            pri_sda_oe_n <= (sl_cnt == 3'h7) ? 1'b1 : sl_sh[7];
            sl_sh        <= {sl_sh[6:0], 1'b0};
            if (sl_cnt == 3'h7)
              sl_state <= SL_RACK;
          end
        SL_RACK:
          if (sl_rise)
            sl_state <= pri_sda_s ? SL_IDLE : SL_ACK;
      endcase
    end
  end

  // Sensor-side master
  asbc_mst_t  ms_state;
  logic [2:0] slot;
  logic [3:0] bc;
  logic [1:0] ph;
  logic [6:0] qcnt;
  logic       tick;
  logic [4:0] tot;
  logic [4:0] cnt;
  logic [4:0] rlen;
  logic [7:0] rx;
  logic       ack_bad;
  logic       push_valid;
  asbc_word_t push_word;
  logic       fifo_in_ready;

  asbc_slot_t cur;
  assign cur = slot_cfg[slot[1:0]];
  wire is_single = (slot[1:0] == 2'h3);
  wire [4:0] room = BURST_MAX - tot;
  wire [4:0] want = is_single ? 5'h01 :
                    ((cur.len < room) ? cur.len : room);
  wire rd_op     = ~is_single | cur.rnw;
  wire is_rd     = (ms_state == MS_RD);
  wire is_frame  = (ms_state == MS_START) | (ms_state == MS_RSTART);
  wire byte_st   = (ms_state == MS_AW) | (ms_state == MS_REG) |
                   (ms_state == MS_AR) | is_rd | (ms_state == MS_WD);
  wire last_byte = ((cnt + 5'h01) == rlen);
  wire [7:0] tx_byte = (ms_state == MS_AW)  ? {cur.dev, 1'b0} :
                       (ms_state == MS_AR)  ? {cur.dev, 1'b1} :
                       (ms_state == MS_REG) ? cur.index : cur.wdata;
  // Last read byte is not acknowledged
  wire sda_bit = (bc == 4'h8) ? (is_rd ? last_byte : 1'b1) :
                 (is_rd ? 1'b1 : tx_byte[~bc[2:0]]);
  // A sensor may hold the clock low; wait before sampling
  wire clk_held  = (ph == 2'h2) & aux_bus_clock_oe_n & ~aux_scl_s;
  wire eng_go    = tick & ~push_valid & ~clk_held;
  wire byte_done = eng_go & (ph == 2'h3) & (bc == 4'h8) & byte_st;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      qcnt <= 7'h00;
      tick <= 1'b0;
    end
    else
    begin
      tick <= (qcnt == QTR_LAST);
      qcnt <= (qcnt == QTR_LAST) ? 7'h00 : qcnt + 7'h01;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ms_state             <= MS_IDLE;
      slot                 <= 3'h0;
      bc                   <= 4'h0;
      ph                   <= 2'h0;
      tot                  <= 5'h00;
      cnt                  <= 5'h00;
      rlen                 <= 5'h00;
      rx                   <= 8'h00;
      ack_bad              <= 1'b0;
      push_valid           <= 1'b0;
      push_word            <= '0;
      slot3_rdata          <= 8'h00;
      aux_nack_event       <= 1'b0;
      round_done           <= 1'b0;
      busy                 <= 1'b0;
      bypass_switch_closed <= 1'b0;
      aux_bus_clock_oe_n   <= 1'b1;
      aux_bus_data_oe_n    <= 1'b1;
    end
    else
    begin
      aux_nack_event       <= 1'b0;
      round_done           <= 1'b0;
      bypass_switch_closed <= bypass_en;
      if (push_valid & fifo_in_ready)
        push_valid <= 1'b0;
      if (bypass_en)
      begin
        // Abort at once and release both aux lines
        ms_state           <= MS_IDLE;
        busy               <= 1'b0;
        ph                 <= 2'h0;
        bc                 <= 4'h0;
        aux_bus_clock_oe_n <= 1'b1;
        aux_bus_data_oe_n  <= 1'b1;
      end
      else if (ms_state == MS_IDLE)
      begin
        if (round_start)
        begin
          slot     <= 3'h0;
          tot      <= 5'h00;
          busy     <= 1'b1;
          ms_state <= MS_SEL;
        end
      end
      else if (ms_state == MS_SEL)
      begin
        if (slot == SLOT_END)
        begin
          busy       <= 1'b0;
          round_done <= 1'b1;
          ms_state   <= MS_IDLE;
        end
        else if (cur.en & (want != 5'h00))
        begin
          rlen     <= want;
          cnt      <= 5'h00;
          ms_state <= MS_START;
        end
        else
          slot <= slot + 3'h1;
      end
      else if (eng_go)
      begin
        ph <= ph + 2'h1;
        unique case (ph)
          2'h0:
            aux_bus_data_oe_n <= is_frame ? 1'b1 :
                                 (ms_state == MS_STOP) ? 1'b0 : sda_bit;
          2'h1:
            aux_bus_clock_oe_n <= 1'b1;
          2'h2:
          begin
            if (is_frame)
              aux_bus_data_oe_n <= 1'b0;
            else if (ms_state == MS_STOP)
              aux_bus_data_oe_n <= 1'b1;
            else if (is_rd & (bc != 4'h8))
              rx <= {rx[6:0], aux_sda_s};
            else if (bc == 4'h8)
              ack_bad <= aux_sda_s;
          end
          2'h3:
          begin
            if (ms_state == MS_STOP)
            begin
              slot     <= slot + 3'h1;
              ms_state <= MS_SEL;
            end
            else
              aux_bus_clock_oe_n <= 1'b0;
            if (ms_state == MS_START)
              ms_state <= MS_AW;
            if (ms_state == MS_RSTART)
              ms_state <= MS_AR;
            if (byte_st)
              bc <= (bc == 4'h8) ? 4'h0 : bc + 4'h1;
            if (byte_done & ~is_rd & ack_bad)
            begin
              aux_nack_event <= 1'b1;
              ms_state       <= MS_STOP;
            end
            else if (byte_done)
            begin
              unique case (ms_state)
                MS_AW:  ms_state <= MS_REG;
                MS_REG: ms_state <= rd_op ? MS_RSTART : MS_WD;
                MS_AR:  ms_state <= MS_RD;
                MS_WD:  ms_state <= MS_STOP;
                default:
                begin
                  cnt <= cnt + 5'h01;
                  if (is_single)
                    slot3_rdata <= rx;
                  else
                  begin
                    push_valid <= 1'b1;
                    push_word  <= '{slot: slot[1:0], data: rx};
                    tot        <= tot + 5'h01;
                  end
                  if (last_byte)
                    ms_state <= MS_STOP;
                end
              endcase
            end
          end
        endcase
      end
    end
  end

  asbc_fifo #(
    .WIDTH ($bits(asbc_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (push_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (push_word),
    .out_valid (stream_valid),
    .out_ready (stream_ready),
    .out_data  (stream_data)
  );

  sequence s_reg_read_done;
    byte_done && ms_state == MS_REG && !ack_bad && rd_op && !bypass_en;
  endsequence

  mode_exclusive_a: assert property (bypass_en |=> ms_state == MS_IDLE)
    else $error("master active in pass-through");
  bypass_quiet_a: assert property (bypass_switch_closed |->
      aux_bus_clock_oe_n && aux_bus_data_oe_n)
    else $error("aux line driven in pass-through");
  switch_follow_a: assert property ($rose(bypass_en) |=>
      bypass_switch_closed)
    else $error("switch did not close");
  slave_only_a: assert property (!pri_sda_oe_n |->
      sl_state inside {SL_ACK, SL_RD})
    else $error("host data driven outside an answer");
  addr_match_a: assert property ((sl_state == SL_ADEC && sl_fall &&
      sl_sh[7:1] == {PRI_ADDR_HI, addr_lsb_s}) |=> !pri_sda_oe_n)
    else $error("own address not acknowledged");
  bypass_slave_a: assert property ((bypass_switch_closed && sl_start) |=>
      sl_state == SL_ADDR)
    else $error("target deaf in pass-through");
  fetch_burst_a: assert property (push_valid |->
      push_word.slot != 2'h3)
    else $error("single slot data in stream");
  axis_len_a: assert property ((ms_state == MS_SEL && slot < 3'h3 &&
      cur.en && cur.len != 5'h00 && cur.len <= room && !bypass_en) |=>
      rlen == $past(cur.len))
    else $error("burst length not as configured");
  burst_cap_a: assert property (tot <= BURST_MAX)
    else $error("burst total above limit");
  single_len_a: assert property ((is_rd && is_single) |->
      rlen == 5'h01)
    else $error("single slot read more than one byte");
  nack_pulse_a: assert property ((byte_done && !is_rd && ack_bad &&
      !bypass_en) |=> aux_nack_event ##1 !aux_nack_event)
    else $error("missing acknowledge not flagged");
  restart_a: assert property (s_reg_read_done |=>
      ms_state == MS_RSTART)
    else $error("no repeated start after index");
  last_nack_a: assert property ((eng_go && ph == 2'h0 && is_rd &&
      bc == 4'h8 && !bypass_en) |=> aux_bus_data_oe_n == last_byte)
    else $error("wrong acknowledge on read byte");
endmodule

//--- include/asbc_params.svh
// Timing, sizing and address constants for the auxiliary sensor bus unit
`ifndef ASBC_PARAMS_SVH
`define ASBC_PARAMS_SVH
`define ASBC_CLK_NS 8
`define ASBC_AUX_KHZ 400
`define ASBC_QTR_NS (1000000 / (4 * `ASBC_AUX_KHZ))
`define ASBC_QTR_CYC ((`ASBC_QTR_NS + `ASBC_CLK_NS - 1) / `ASBC_CLK_NS)
`define ASBC_BURST_MAX 24
`define ASBC_BURST_SLOTS 3
`define ASBC_SLOT_COUNT 4
`define ASBC_FIFO_DEPTH 16
`define ASBC_PRI_ADDR_HI 6'h34
`endif

//--- include/asbc_pkg.sv
// Types shared by the auxiliary sensor bus unit
package asbc_pkg;
  typedef enum logic [3:0] {
    MS_IDLE   = 4'h0,
    MS_SEL    = 4'h1,
    MS_START  = 4'h2,
    MS_AW     = 4'h3,
    MS_REG    = 4'h4,
    MS_RSTART = 4'h5,
    MS_AR     = 4'h6,
    MS_RD     = 4'h7,
    MS_WD     = 4'h8,
    MS_STOP   = 4'h9
  } asbc_mst_t;
  typedef enum logic [2:0] {
    SL_IDLE = 3'h0,
    SL_ADDR = 3'h1,
    SL_ADEC = 3'h2,
    SL_ACK  = 3'h3,
    SL_WR   = 3'h4,
    SL_WACK = 3'h5,
    SL_RD   = 3'h6,
    SL_RACK = 3'h7
  } asbc_slv_t;
  typedef struct packed {
    logic       en;
    logic       rnw;
    logic [6:0] dev;
    logic [7:0] index;
    logic [4:0] len;
    logic [7:0] wdata;
  } asbc_slot_t;
  typedef struct packed {
    logic [1:0] slot;
    logic [7:0] data;
  } asbc_word_t;
endpackage

//--- design/asbc_fifo.sv
// Sensor data FIFO with registered read port
`timescale 1ns/10ps
module asbc_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  // DEPTH must be a power of two; pointers wrap naturally
  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      fill;

  wire push = in_valid & in_ready;
  wire pop  = (fill != '0) & (~out_valid | out_ready);

  assign in_ready = (fill != FULL);

  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      fill      <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      fill <= fill + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      if (pop)
      begin
        out_data  <= mem[rd_ptr];
        out_valid <= 1'b1;
      end
      else if (out_ready)
        out_valid <= 1'b0;
    end
  end
endmodule

//--- test/asbc_sensor_model.sv
// Behavioural two-wire sensor with register file and clock stretching
`timescale 1ns/10ps
module asbc_sensor_model #(
  parameter logic [6:0] ADDR       = 7'h1E,
  parameter int         STRETCH_NS = 2000
) (
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_low,
  output logic      sda_low,
  output int        starts,
  output int        stops
);
  logic [7:0] mem [256];
  logic [7:0] sh    = 8'h00;
  logic [7:0] tx    = 8'h00;
  logic [7:0] idx   = 8'h00;
  logic       act   = 1'b0;
  logic       rd    = 1'b0;
  logic       first = 1'b0;
  logic       ixp   = 1'b0;
  logic       mack  = 1'b0;
  int         bitc  = 0;

  initial
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    starts = 0;
    stops = 0;
    // Register i holds 40h plus i so any index is predictable
    for (int i = 0; i < 256; i++)
      mem[i] = 8'h40 + 8'(i);
  end

  always @(negedge sda)
    if (scl === 1'b1)
    begin
      starts++;
      act = 1'b1;
      first = 1'b1;
      rd = 1'b0;
      // The clock fall that closes the start is not a data bit
      bitc = -1;
    end

  always @(posedge sda)
    if (scl === 1'b1)
    begin
      stops++;
      act = 1'b0;
    end

  // Own ack reads back low, so an address match also starts the read
  always @(posedge scl)
    if (bitc < 8)
      sh = {sh[6:0], sda};
    else
      mack = ~sda;

  // Data changes right at the clock fall: zero hold time, no margin given
  always @(negedge scl)
    if (act)
    begin
      if (bitc < 7)
      begin
        bitc++;
        if (rd)
          sda_low = ~tx[7 - bitc];
      end
      else if (bitc == 7)
      begin
        bitc = 8;
        sda_low = 1'b0;
        if (first)
        begin
          act = (sh[7:1] == ADDR);
          rd = sh[0];
          first = 1'b0;
          ixp = 1'b1;
          sda_low = act;
        end
        else if (!rd)
        begin
          if (ixp)
            idx = sh;
          else
            mem[idx++] = sh;
          ixp = 1'b0;
          sda_low = 1'b1;
        end
      end
      else
      begin
        bitc = 0;
        sda_low = 1'b0;
        if (rd && mack)
        begin
          tx = mem[idx++];
          sda_low = ~tx[7];
        end
        else if (rd)
          act = 1'b0;
        if (act && STRETCH_NS > 0)
        begin
          scl_low = 1'b1;
          #(STRETCH_NS);
          scl_low = 1'b0;
        end
      end
    end
endmodule

//--- test/aux_sensor_bus_controller_tb.sv
// Self-checking bench for the auxiliary sensor bus controller
`timescale 1ns/10ps
module aux_sensor_bus_controller_tb import asbc_pkg::*; ;
  localparam logic [5:0] DEV_HI   = 6'h2B;
  localparam logic [6:0] SEN_ADDR = 7'h1E;
  logic             clk_sys      = 1'b0;
  logic             rst          = 1'b1;
  logic             host_scl_low = 1'b0;
  logic             host_sda_low = 1'b0;
  logic             strap        = 1'b0;
  logic             bypass_en    = 1'b0;
  logic             round_start  = 1'b0;
  logic             stream_ready = 1'b0;
  logic             aux_drv      = 1'b0;
  asbc_slot_t [3:0] slot_cfg     = '0;
  asbc_word_t       stream_data;
  logic       [7:0] slot3_rdata;
  logic             pri_sda_oe_n, aux_bus_clock_oe_n, aux_bus_data_oe_n;
  logic             stream_valid, aux_nack_event, round_done, busy;
  logic             bypass_switch_closed, sen_scl_low, sen_sda_low;
  logic             pri_sda_out, aux_clk_out, aux_dat_out;
  int               sen_starts, sen_stops;
  int               miscompares  = 0;
  int               checks       = 0;

  // Open-drain wires with pull-ups; the bypass switch joins both buses
  wire a_scl_pull = ~aux_bus_clock_oe_n | sen_scl_low;
  wire a_sda_pull = ~aux_bus_data_oe_n | sen_sda_low;
  wire p_sda_pull = host_sda_low | ~pri_sda_oe_n;
  wire sw         = bypass_switch_closed;
  wire aux_scl    = ~(a_scl_pull | (sw & host_scl_low));
  wire aux_sda    = ~(a_sda_pull | (sw & p_sda_pull));
  wire pri_scl    = ~(host_scl_low | (sw & a_scl_pull));
  wire pri_sda    = ~(p_sda_pull | (sw & a_sda_pull));

  always #4 clk_sys = ~clk_sys;

  always @(negedge clk_sys)
    if (sw === 1'b1 && (aux_bus_clock_oe_n !== 1'b1
        || aux_bus_data_oe_n !== 1'b1))
      aux_drv = 1'b1;

  asbc_ctrl #(.PRI_ADDR_HI(DEV_HI)) dut_u (
    .clk_sys(clk_sys), .rst(rst), .pri_scl_in(pri_scl),
    .pri_sda_in(pri_sda), .pri_sda_out(pri_sda_out),
    .pri_sda_oe_n(pri_sda_oe_n),
    .address_select_pin(strap), .aux_bus_clock_in(aux_scl),
    .aux_bus_clock_out(aux_clk_out),
    .aux_bus_clock_oe_n(aux_bus_clock_oe_n),
    .aux_bus_data_in(aux_sda), .aux_bus_data_out(aux_dat_out),
    .aux_bus_data_oe_n(aux_bus_data_oe_n), .bypass_en(bypass_en),
    .round_start(round_start), .slot_cfg(slot_cfg),
    .stream_data(stream_data), .stream_valid(stream_valid),
    .stream_ready(stream_ready), .slot3_rdata(slot3_rdata),
    .aux_nack_event(aux_nack_event), .round_done(round_done),
    .busy(busy), .bypass_switch_closed(bypass_switch_closed)
  );

  asbc_sensor_model #(.ADDR(SEN_ADDR), .STRETCH_NS(2000)) sen_u (
    .scl(aux_scl), .sda(aux_sda), .scl_low(sen_scl_low),
    .sda_low(sen_sda_low), .starts(sen_starts), .stops(sen_stops)
  );

  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1)
    begin
      miscompares++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task report_and_stop;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Quarter of a 160 ns host bus bit
  task hq;
    repeat (5) @(negedge clk_sys);
  endtask

  // Release the host clock and wait out any stretching
  task hrise;
    host_scl_low = 1'b0;
    repeat (1000)
      if (pri_scl !== 1'b1)
        @(negedge clk_sys);
    hq;
    hq;
  endtask

  task hstart;
    host_sda_low = 1'b0;
    hq;
    hrise;
    host_sda_low = 1'b1;
    hq;
    host_scl_low = 1'b1;
    hq;
  endtask

  task hstop;
    host_sda_low = 1'b1;
    hq;
    hrise;
    host_sda_low = 1'b0;
    hq;
  endtask

  // Eight data bits plus the ack bit, most significant first
  task automatic hx(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--)
    begin
      host_sda_low = ~tx[i];
      hq;
      hrise;
      rx[i] = pri_sda;
      host_scl_low = 1'b1;
      hq;
    end
  endtask

  task automatic hread_dev(input logic lsb, output logic ack,
                           output logic [7:0] d);
    logic [8:0] rx;
    hstart;
    hx({DEV_HI, lsb, 1'b1, 1'b1}, rx);
    ack = ~rx[0];
    hx(9'h1FF, rx);
    d = rx[8:1];
    hstop;
  endtask

  task pulse_start;
    round_start = 1'b1;
    @(negedge clk_sys);
    round_start = 1'b0;
  endtask

  task t_reset;
    repeat (10) @(negedge clk_sys);
    chk(pri_sda_oe_n === 1'b1 && aux_bus_clock_oe_n === 1'b1
        && aux_bus_data_oe_n === 1'b1, "pins driven in reset");
    chk(busy === 1'b0 && stream_valid === 1'b0 && slot3_rdata === 8'h00
        && sw === 1'b0, "reset state");
    chk({pri_sda_out, aux_clk_out, aux_dat_out} === 3'h0,
        "pull value not low");
    rst = 1'b0;
    repeat (4) @(negedge clk_sys);
  endtask

  task automatic t_target;
    logic       ack;
    logic [7:0] d;
    for (int s = 0; s < 2; s++)
    begin
      strap = s[0];
      repeat (4) @(negedge clk_sys);
      hread_dev(s[0], ack, d);
      chk(ack === 1'b1 && d === 8'h00, "own address not served");
      hread_dev(~s[0], ack, d);
      chk(ack === 1'b0, "other address acked");
    end
  endtask

  task automatic t_round;
    int   st0, sp0, nacks;
    logic done, pri_drv;
    st0 = sen_starts;
    sp0 = sen_stops;
    nacks = 0;
    done = 1'b0;
    pri_drv = 1'b0;
    slot_cfg[0] = '{1'b1, 1'b1, SEN_ADDR, 8'h02, 5'h06, 8'h00};
    slot_cfg[1] = '{1'b1, 1'b1, 7'h2A, 8'h00, 5'h02, 8'h00};
    slot_cfg[3] = '{1'b1, 1'b1, SEN_ADDR, 8'h10, 5'h01, 8'h00};
    pulse_start;
    chk(busy === 1'b1, "round not started");
    for (int i = 0; i < 80000 && !done; i++)
    begin
      @(negedge clk_sys);
      if (aux_nack_event === 1'b1)
        nacks++;
      if (pri_sda_oe_n !== 1'b1)
        pri_drv = 1'b1;
      done = (round_done === 1'b1);
    end
    chk(done && busy === 1'b0, "round did not finish");
    chk(nacks == 1, "missing sensor not flagged");
    chk(slot3_rdata === 8'h50, "single byte slot read");
    chk(sen_starts - st0 == 5 && sen_stops - sp0 == 3, "framing");
    chk(pri_drv === 1'b0, "host bus driven by master");
    for (int i = 0; i < 6; i++)
    begin
      chk(stream_valid === 1'b1
          && stream_data === {2'h0, 8'h42 + 8'(i)}, "axis byte");
      stream_ready = 1'b1;
      @(negedge clk_sys);
    end
    stream_ready = 1'b0;
    chk(stream_valid === 1'b0, "extra words");
  endtask

  task automatic t_bypass;
    logic [8:0] rx;
    logic       ack, done;
    logic [7:0] d;
    bypass_en = 1'b1;
    pulse_start;
    @(negedge clk_sys);
    chk(busy === 1'b0, "round ran in pass-through");
    chk(sw === 1'b1, "switch open");
    hstart;
    hx({SEN_ADDR, 1'b0, 1'b1}, rx);
    chk(rx[0] === 1'b0, "sensor not reached");
    hx({8'h05, 1'b1}, rx);
    hstart;
    hx({SEN_ADDR, 1'b1, 1'b1}, rx);
    hx(9'h1FF, rx);
    hstop;
    chk(rx[8:1] === 8'h45, "sensor data via bypass");
    hread_dev(strap, ack, d);
    chk(ack === 1'b1 && d === 8'h50, "device silent");
    chk(aux_drv === 1'b0, "aux master drove pins");
    bypass_en = 1'b0;
    slot_cfg = '0;
    slot_cfg[3] = '{1'b1, 1'b0, SEN_ADDR, 8'h20, 5'h01, 8'hA5};
    repeat (2) @(negedge clk_sys);
    chk(sw === 1'b0, "switch stuck");
    pulse_start;
    done = 1'b0;
    for (int i = 0; i < 20000 && !done; i++)
    begin
      done = (round_done === 1'b1);
      @(negedge clk_sys);
    end
    chk(done, "master did not resume");
    chk(sen_u.mem[8'h20] === 8'hA5, "single byte write");
  endtask

  initial
  begin
    t_reset;
    t_target;
    t_round;
    t_bypass;
    report_and_stop;
  end

  // Whole run is about 0.5 ms; give it half as much again
  initial
  begin
    #760000;
    miscompares++;
    $display("unexpected at %0t: watchdog expired", $time);
    report_and_stop;
  end
endmodule
